// *** shared/bitwise_alu_pkg.sv ***
// constants, carriers and decode helpers for the inverse-move / or-with-complement unit
// How it works
// - immediate inverse move writes complemented expanded immediate
// - immediates expand from i, high, low fields
// - immediate inverse move to 13/15 unpredictable
// - flags: N bit31, Z zero, C carry, V kept
// - wide forms set flags only when S set
// - narrow register move: flags outside block, no shift
// - register forms shift source, complement for move
// - wide shift from type and amount fields
// - wide register move with 13/15 unpredictable
// - nonzero shift only in wide register form
// - negate alias equals reverse subtract zero, flags outside block
// - no-operation hint changes no state
// - immediate or-with-complement: first OR NOT immediate
// - immediate or-complement with 1111 becomes move
// - immediate or-complement: bad destination or first operand
// - register or-complement: first OR NOT shifted
// - register or-complement with 1111 becomes move
// - register or-complement: bad destination, operands unpredictable
// - register carry comes from shifting second operand
`default_nettype none
package bitwise_alu_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0]  REG_SP = 4'hd;
  localparam logic [3:0]  REG_PC = 4'hf;
  // narrow encodings, opcode in bits 15:6; the narrow and wide no-op hints match the whole instruction
  localparam logic [9:0]  NARROW_INVERSE_MOVE = 10'h10f;
  localparam logic [9:0]  NARROW_REVERSE_SUB  = 10'h109;
  localparam logic [15:0] NARROW_NOP          = 16'hbf00;
  localparam logic [31:0] WIDE_NOP            = 32'hf3af8000;
  // wide immediate form: first halfword bits 15:11 and 9:5
  localparam logic [4:0]  WIDE_IMM_MAJOR      = 5'h1e;
  localparam logic [4:0]  WIDE_IMM_OPCODE     = 5'h03;
  // wide register form: first halfword bits 15:5
  localparam logic [10:0] WIDE_REG_OPCODE     = 11'h753;
  localparam logic [31:0] MOST_NEGATIVE       = 32'h80000000;

  typedef enum logic [2:0] {SHIFT_LSL, SHIFT_LSR, SHIFT_ASR, SHIFT_ROR, SHIFT_RRX} shift_type_e;
  typedef enum logic [2:0] {
    OP_NONE, OP_NOP, OP_INV_IMM, OP_INV_REG, OP_ORC_IMM, OP_ORC_REG, OP_NEGATE
  } op_e;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_s;

  typedef struct packed {
    logic              en;
    logic [3:0]        addr;
    logic [DATA_W-1:0] data;
  } writeback_s;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic              carry;
  } operand_s;

  typedef struct packed {
    shift_type_e kind;
    logic [5:0]  amount;
  } shift_s;

  typedef struct packed {
    writeback_s wb;
    logic       flags_we;
    flags_s     flags;
    logic       unpredictable;
    logic       done;
  } alu_state_s;

  localparam alu_state_s STATE_RESET = '0;

  function automatic operand_s modified_immediate_expand(input logic [11:0] imm12,
                                                         input logic        carry_in);
    operand_s    r;
    logic [31:0] base;
    logic [4:0]  rot;
    base    = {24'h0, imm12[7:0]};
    rot     = imm12[11:7];
    r.value = base;
    r.carry = carry_in;
    if (imm12[11:10] == 2'b00) begin
      case (imm12[9:8])
        2'b00:   r.value = base;
        2'b01:   r.value = {8'h0, imm12[7:0], 8'h0, imm12[7:0]};
        2'b10:   r.value = {imm12[7:0], 8'h0, imm12[7:0], 8'h0};
        default: r.value = {4{imm12[7:0]}};
      endcase
    end else begin
      // rotation is at least 8 here, so the left part never shifts by 32
      base    = {24'h0, 1'b1, imm12[6:0]};
      r.value = (base >> rot) | (base << (6'd32 - {1'b0, rot}));
      r.carry = r.value[31];
    end
    return r;
  endfunction

  function automatic shift_s immediate_shift_decode(input logic [1:0] kind,
                                                    input logic [4:0] imm5);
    shift_s s;
    s.amount = {1'b0, imm5};
    case (kind)
      2'b00:   s.kind = SHIFT_LSL;
      2'b01:   s.kind = SHIFT_LSR;
      2'b10:   s.kind = SHIFT_ASR;
      default: s.kind = (imm5 == 5'h0) ? SHIFT_RRX : SHIFT_ROR;
    endcase
    if (kind != 2'b00 && imm5 == 5'h0) begin
      s.amount = (kind == 2'b11) ? 6'h01 : 6'h20;
    end
    return s;
  endfunction
endpackage
`default_nettype wire

// *** rtl/barrel_shift_unit.sv ***
// shift with carry for the register operand forms
`timescale 1ns/1ps
`default_nettype none
module barrel_shift_unit
  import bitwise_alu_pkg::*;
(
  input  wire logic [DATA_W-1:0] value,
  input  wire shift_s            shift,
  input  wire logic              carry_in,
  output logic [DATA_W-1:0]      result,
  output logic                   carry_out
);
  logic        [63:0] wide;
  logic signed [63:0] swide;

  always_comb begin
    wide      = 64'h0;
    swide     = 64'sh0;
    result    = value;
    carry_out = carry_in;
    if (shift.amount != 6'h0) begin
      case (shift.kind)
        SHIFT_LSL: begin
          wide      = {32'h0, value} << shift.amount;
          result    = wide[31:0];
          carry_out = wide[32];
        end
        SHIFT_LSR: begin
          wide      = {value, 32'h0} >> shift.amount;
          result    = wide[63:32];
          carry_out = wide[31];
        end
        SHIFT_ASR: begin
          swide     = $signed({value, 32'h0}) >>> shift.amount;
          result    = swide[63:32];
          carry_out = swide[31];
        end
        SHIFT_ROR: begin
          result    = (value >> shift.amount[4:0])
                    | (value << (6'd32 - {1'b0, shift.amount[4:0]}));
          carry_out = result[31];
        end
        SHIFT_RRX: begin
          result    = {carry_in, value[31:1]};
          carry_out = value[0];
        end
        default: begin
          result    = value;
          carry_out = carry_in;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/bitwise_not_ornot_alu.sv ***
// execute-stage unit for inverse move, or-with-complement, negate alias and no-op hint
`timescale 1ns/1ps
`default_nettype none
module bitwise_not_ornot_alu
  import bitwise_alu_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              instr_valid,
  input  wire logic [31:0]       instr,
  input  wire logic              is_wide,
  input  wire logic              in_conditional_block,
  input  wire logic              condition_passed,
  input  wire flags_s            flags_in,
  input  wire logic [DATA_W-1:0] first_operand_data,
  input  wire logic [DATA_W-1:0] second_operand_data,
  output logic [3:0]             first_operand_register,
  output logic [3:0]             second_operand_register,
  output writeback_s             writeback,
  output logic                   flags_we,
  output flags_s                 program_status_flags,
  output logic                   unpredictable,
  output logic                   done
);
  alu_state_s        state;
  alu_state_s        next_state;
  op_e               op;
  logic [3:0]        rd;
  logic [3:0]        opa_reg;
  logic [3:0]        opb_reg;
  logic              setflags;
  logic              bad;
  logic [11:0]       imm12;
  shift_s            shift;
  operand_s          expansion;
  logic [DATA_W-1:0] shifted;
  logic              shift_carry;
  logic [DATA_W-1:0] operand2;
  logic              carry;
  logic [DATA_W:0]   neg_sum;
  logic [DATA_W-1:0] result;
  flags_s            new_flags;
  logic              take;
  logic [15:0]       hw1;
  logic [15:0]       hw2;

  assign hw1 = instr[31:16];
  assign hw2 = instr[15:0];

  function automatic logic is_sp_or_pc(input logic [3:0] r);
    return (r == REG_SP) || (r == REG_PC);
  endfunction

  // decode; anything not recognised leaves op at none and the unit idle
  always_comb begin
    op       = OP_NONE;
    rd       = 4'h0;
    opa_reg  = 4'h0;
    opb_reg  = 4'h0;
    setflags = 1'b0;
    bad      = 1'b0;
    imm12    = 12'h0;
    shift    = '{kind: SHIFT_LSL, amount: 6'h0};
    if (is_wide) begin
      if (instr == WIDE_NOP) begin
        op = OP_NOP;
      end else if (hw1[15:11] == WIDE_IMM_MAJOR && hw1[9:5] == WIDE_IMM_OPCODE
                   && !hw2[15]) begin
        opa_reg  = hw1[3:0];
        rd       = hw2[11:8];
        setflags = hw1[4];
        imm12    = {hw1[10], hw2[14:12], hw2[7:0]};
        if (opa_reg == REG_PC) begin
          op  = OP_INV_IMM;
          bad = is_sp_or_pc(rd);
        end else begin
          op  = OP_ORC_IMM;
          bad = is_sp_or_pc(rd) || opa_reg == REG_SP;
        end
      end else if (hw1[15:5] == WIDE_REG_OPCODE && !hw2[15]) begin
        opa_reg  = hw1[3:0];
        rd       = hw2[11:8];
        opb_reg  = hw2[3:0];
        setflags = hw1[4];
        shift    = immediate_shift_decode(hw2[5:4], {hw2[14:12], hw2[7:6]});
        if (opa_reg == REG_PC) begin
          op  = OP_INV_REG;
          bad = is_sp_or_pc(rd) || is_sp_or_pc(opb_reg);
        end else begin
          op  = OP_ORC_REG;
          bad = is_sp_or_pc(rd) || is_sp_or_pc(opb_reg) || opa_reg == REG_SP;
        end
      end
    end else begin
      if (hw2 == NARROW_NOP) begin
        op = OP_NOP;
      end else if (hw2[15:6] == NARROW_INVERSE_MOVE) begin
        op       = OP_INV_REG;
        rd       = {1'b0, hw2[2:0]};
        opb_reg  = {1'b0, hw2[5:3]};
        setflags = !in_conditional_block;
        // the narrow form has no shift field at all
        shift    = '{kind: SHIFT_LSL, amount: 6'h0};
      end else if (hw2[15:6] == NARROW_REVERSE_SUB) begin
        op       = OP_NEGATE;
        rd       = {1'b0, hw2[2:0]};
        opb_reg  = {1'b0, hw2[5:3]};
        setflags = !in_conditional_block;
      end
    end
  end

  assign first_operand_register  = opa_reg;
  assign second_operand_register = opb_reg;

  always_comb begin
    expansion = modified_immediate_expand(imm12, flags_in.c);
  end

  // carry-in is the live carry flag; the shifter sees the second operand only
  barrel_shift_unit u_shift (
    .value     (second_operand_data),
    .shift     (shift),
    .carry_in  (flags_in.c),
    .result    (shifted),
    .carry_out (shift_carry)
  );

  always_comb begin
    operand2 = shifted;
    carry    = shift_carry;
    if (op == OP_INV_IMM || op == OP_ORC_IMM) begin
      operand2 = expansion.value;
      carry    = expansion.carry;
    end
    neg_sum = {1'b0, ~second_operand_data} + 33'h1;
    case (op)
      OP_INV_IMM: result = ~operand2;
      OP_INV_REG: result = ~operand2;
      OP_ORC_IMM: result = first_operand_data | ~operand2;
      OP_ORC_REG: result = first_operand_data | ~operand2;
      OP_NEGATE:  result = neg_sum[DATA_W-1:0];
      default:    result = '0;
    endcase
    new_flags.n = result[31];
    new_flags.z = (result == '0);
    new_flags.c = (op == OP_NEGATE) ? neg_sum[DATA_W] : carry;
    // only the subtract alias can overflow; logic ops keep V
    new_flags.v = (op == OP_NEGATE) ? (second_operand_data == MOST_NEGATIVE) : flags_in.v;
  end

  assign take = instr_valid && op != OP_NONE && condition_passed;

  always_comb begin
    next_state               = STATE_RESET;
    next_state.flags         = flags_in;
    next_state.done          = instr_valid && op != OP_NONE;
    // unpredictable encodings are dropped rather than given a made-up result
    next_state.unpredictable = take && bad;
    if (take && !bad && op != OP_NOP) begin
      next_state.wb.en    = 1'b1;
      next_state.wb.addr  = rd;
      next_state.wb.data  = result;
      next_state.flags_we = setflags;
      if (setflags) begin
        next_state.flags = new_flags;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign writeback            = state.wb;
  assign flags_we             = state.flags_we;
  assign program_status_flags = state.flags;
  assign unpredictable        = state.unpredictable;
  assign done                 = state.done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_issue;
    instr_valid && condition_passed && op != OP_NONE && !bad;
  endsequence

  sequence s_quiet;
    !writeback.en && !flags_we;
  endsequence

  AST_MOVE_IMM_RESULT: assert property (
    s_issue ##0 (op == OP_INV_IMM) |=>
      writeback.en && writeback.data == ~$past(expansion.value)
      && writeback.addr == $past(rd))
    else $error("inverse move immediate result wrong");

  AST_ORC_REG_RESULT: assert property (
    s_issue ##0 (op == OP_ORC_REG) |=>
      writeback.en && writeback.data == ($past(first_operand_data) | ~$past(shifted)))
    else $error("or with complement register result wrong");

  AST_ORC_IMM_RESULT: assert property (
    s_issue ##0 (op == OP_ORC_IMM) |=>
      writeback.data == ($past(first_operand_data) | ~$past(expansion.value)))
    else $error("or with complement immediate result wrong");

  AST_FLAGS_NZ: assert property (
    flags_we |-> program_status_flags.n == writeback.data[31]
      && program_status_flags.z == (writeback.data == '0))
    else $error("N or Z does not follow result");

  AST_V_KEPT: assert property (
    s_issue ##0 (op != OP_NEGATE && setflags) |=>
      flags_we && program_status_flags.v == $past(flags_in.v)
      && program_status_flags.c == $past(carry))
    else $error("V changed or C not from carry out");

  AST_S_CLEAR_NO_FLAGS: assert property (
    instr_valid && is_wide && op != OP_NONE && !hw1[4] |=> !flags_we)
    else $error("flags written with S clear");

  AST_NARROW_IN_BLOCK: assert property (
    instr_valid && !is_wide && op == OP_INV_REG && in_conditional_block |=>
      !flags_we ##0 (writeback.data == ~$past(second_operand_data) || !writeback.en))
    else $error("narrow move set flags inside block or shifted");

  AST_UNPREDICTABLE_DROP: assert property (
    instr_valid && condition_passed && op != OP_NONE && bad |=> unpredictable ##0 s_quiet)
    else $error("unpredictable encoding changed state");

  AST_COND_FAIL: assert property (
    instr_valid && !condition_passed |=> s_quiet ##1 1'b1)
    else $error("failed condition changed state");

  AST_NOP_QUIET: assert property (
    instr_valid && op == OP_NOP |=> done && !writeback.en && !flags_we)
    else $error("no-op hint changed state");

  AST_NEGATE_FLAGS: assert property (
    s_issue ##0 (op == OP_NEGATE && setflags) |=>
      writeback.data == (32'h0 - $past(second_operand_data))
      && program_status_flags.c == ($past(second_operand_data) == 32'h0)
      && program_status_flags.v == ($past(second_operand_data) == MOST_NEGATIVE))
    else $error("negate alias wrong");

  // flag-setting issue of a real operation, as opposed to the hint
  sequence s_flag_issue;
    s_issue ##0 (setflags && op != OP_NOP);
  endsequence

  AST_WRITE_ADDR: assert property (
    s_issue ##0 (op != OP_NOP) |=> writeback.en && writeback.addr == $past(rd))
    else $error("register write missing or misaddressed");

  AST_INV_REG_RESULT: assert property (
    s_issue ##0 (op == OP_INV_REG) |=> writeback.data == ~$past(shifted))
    else $error("inverse move register result wrong");

  AST_REG_CARRY: assert property (
    s_flag_issue ##0 (op == OP_INV_REG || op == OP_ORC_REG) |=>
      program_status_flags.c == $past(shift_carry))
    else $error("register carry not from shifter");

  AST_IMM_CARRY: assert property (
    s_flag_issue ##0 (op == OP_INV_IMM || op == OP_ORC_IMM) |=>
      program_status_flags.c == $past(expansion.carry))
    else $error("immediate carry not from expansion");

  AST_S_SET_FLAGS: assert property (
    s_issue ##0 (is_wide && hw1[4] && op != OP_NOP) |=> flags_we)
    else $error("flags not written with S set");

  AST_NARROW_NO_SHIFT: assert property (
    instr_valid && !is_wide |-> shift.amount == 6'h0)
    else $error("narrow form shifted");

  AST_MOVE_SELECT: assert property (
    instr_valid && is_wide && op == OP_INV_IMM |-> hw1[3:0] == REG_PC)
    else $error("immediate move without first field all ones");

  AST_REG_MOVE_SELECT: assert property (
    instr_valid && is_wide && op == OP_ORC_REG |-> hw1[3:0] != REG_PC)
    else $error("register or-complement with first field all ones");

  AST_IMM_BAD_DEST: assert property (
    instr_valid && op == OP_INV_IMM && is_sp_or_pc(rd) |-> bad)
    else $error("immediate move destination not refused");

  AST_IMM_BAD_FIRST: assert property (
    instr_valid && op == OP_ORC_IMM && opa_reg == REG_SP |-> bad)
    else $error("immediate first operand not refused");

  AST_REG_BAD_SOURCE: assert property (
    instr_valid && is_wide && op == OP_INV_REG && is_sp_or_pc(opb_reg) |-> bad)
    else $error("register move source not refused");

  AST_UNPRED_PULSE: assert property (
    unpredictable |-> done && !writeback.en && !flags_we)
    else $error("unpredictable pulse with a write");

  AST_FLAG_WRITE_PAIRED: assert property (
    flags_we |-> writeback.en)
    else $error("flag write without register write");

  // first cycle after reset holds cleared flags, not the input
  AST_FLAGS_ECHO: assert property (
    $past(rst_n) && !flags_we |-> program_status_flags == $past(flags_in))
    else $error("flags changed without a flag write");

  AST_DONE_FOLLOWS: assert property (
    done |-> $past(instr_valid))
    else $error("done without an instruction");

  AST_UNKNOWN_IDLE: assert property (
    instr_valid && op == OP_NONE |=> !done && s_quiet)
    else $error("unrecognised encoding answered");
endmodule
`default_nettype wire

// *** verif/bitwise_not_ornot_alu_tb.sv ***
// self-checking bench for the inverse-move / or-with-complement unit
`timescale 1ns/1ps
`default_nettype none
module bitwise_not_ornot_alu_tb
  import bitwise_alu_pkg::*;
;
  localparam logic [4:0] NC    = 5'h10;
  localparam int         LIMIT = 2000;
  logic        clock;
  logic        rst_n;
  logic        instr_valid;
  logic [31:0] instr;
  logic        is_wide;
  logic        in_conditional_block;
  logic        condition_passed;
  flags_s      flags_in;
  logic [31:0] first_operand_data;
  logic [31:0] second_operand_data;
  logic [3:0]  first_operand_register;
  logic [3:0]  second_operand_register;
  writeback_s  writeback;
  logic        flags_we;
  flags_s      program_status_flags;
  logic        unpredictable;
  logic        done;
  int          miscompares;
  int          checks;
  int          cycles;

  bitwise_not_ornot_alu i_dut (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .instr_valid             (instr_valid),
    .instr                   (instr),
    .is_wide                 (is_wide),
    .in_conditional_block    (in_conditional_block),
    .condition_passed        (condition_passed),
    .flags_in                (flags_in),
    .first_operand_data      (first_operand_data),
    .second_operand_data     (second_operand_data),
    .first_operand_register  (first_operand_register),
    .second_operand_register (second_operand_register),
    .writeback               (writeback),
    .flags_we                (flags_we),
    .program_status_flags    (program_status_flags),
    .unpredictable           (unpredictable),
    .done                    (done)
  );

  always #25 clock = ~clock;

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard: well above the roughly 60 cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // eo = {done, unpredictable, flags_we, writeback.en}; valid is left high for back-to-back
  task automatic op(input logic [31:0] ins, input logic wide, input logic blk,
                    input logic cp, input logic [3:0] fin, input logic [31:0] a,
                    input logic [31:0] b, input logic [4:0] ern, input logic [4:0] erm,
                    input logic [3:0] eo, input logic [3:0] ef, input logic [3:0] ea,
                    input logic [31:0] ed);
    instr_valid = 1'b1;
    instr = ins;
    is_wide = wide;
    in_conditional_block = blk;
    condition_passed = cp;
    flags_in = fin;
    first_operand_data = a;
    second_operand_data = b;
    #1;
    if (!ern[4]) chk(first_operand_register, ern[3:0]);
    if (!erm[4]) chk(second_operand_register, erm[3:0]);
    @(posedge clock);
    #1;
    chk({done, unpredictable, flags_we, writeback.en}, eo);
    // flags only change on a flag write, else they echo the input
    chk(program_status_flags, eo[1] ? ef : fin);
    if (eo[0]) chk({writeback.addr, writeback.data}, {ea, ed});
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge clock);
    #1;
    chk({done, writeback.en, flags_we, unpredictable}, 4'h0);
  endtask

  task automatic t_move_imm();
    op(32'hf07f427f, 1, 0, 1, 4'h1, 0, 0, NC, 5'h00, 4'hb, 4'h3, 4'h2, 32'h00ffffff);
    op(32'hf47f037f, 1, 0, 1, 4'h3, 0, 0, NC, 5'h00, 4'hb, 4'h9, 4'h3, 32'hff00ffff);
    op(32'hf06f11ab, 1, 0, 1, 4'hf, 0, 0, NC, 5'h00, 4'h9, 4'h0, 4'h1, 32'hff54ff54);
    op(32'hf06f21ab, 1, 0, 1, 4'h0, 0, 0, NC, 5'h00, 4'h9, 4'h0, 4'h1, 32'h54ff54ff);
    op(32'hf06f31ab, 1, 0, 1, 4'h0, 0, 0, NC, 5'h00, 4'h9, 4'h0, 4'h1, 32'h54545454);
    op(32'hf07f30ff, 1, 0, 1, 4'h2, 0, 0, NC, 5'h00, 4'hb, 4'h6, 4'h0, 32'h0);
    op(32'hf06f0d00, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hf06f0f00, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    idle();
  endtask

  task automatic t_or_complement_imm();
    op(32'hf07335ab, 1, 0, 1, 4'h0, 32'h01000001, 0, 5'h03, 5'h00, 4'hb, 4'h0, 4'h5,
       32'h55545455);
    op(32'hf06d0100, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hf0620f00, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    // first-operand field 1111 must fall back to the move
    op(32'hf06f0400, 1, 0, 1, 4'h0, 32'h0, 0, NC, NC, 4'h9, 4'h0, 4'h4, 32'hffffffff);
    idle();
  endtask

  task automatic t_register_forms();
    op(32'hea7f1206, 1, 0, 1, 4'h0, 0, 32'hf0000001, NC, 5'h06, 4'hb, 4'ha, 4'h2,
       32'hffffffef);
    op(32'hea740325, 1, 0, 1, 4'h1, 0, 32'h80000000, 5'h04, 5'h05, 4'hb, 4'h7, 4'h3,
       32'h0);
    op(32'hea640355, 1, 0, 1, 4'h0, 32'hf, 32'hfffffff0, 5'h04, 5'h05, 4'h9, 4'h0, 4'h3,
       32'h8000000f);
    op(32'hea742335, 1, 0, 1, 4'h0, 0, 32'h000000ff, 5'h04, 5'h05, 4'hb, 4'h2, 4'h3,
       32'h00ffffff);
    op(32'hea740335, 1, 0, 1, 4'h2, 0, 32'h3, 5'h04, 5'h05, 4'hb, 4'h2, 4'h3,
       32'h7ffffffe);
    op(32'hea6f020d, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hea6f0f02, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hea640d05, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hea6d0205, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hea64020f, 1, 0, 1, 4'h0, 0, 0, NC, NC, 4'hc, 4'h0, 4'h0, 32'h0);
    op(32'hea6f0206, 1, 0, 1, 4'h0, 0, 32'h0000ff00, NC, 5'h06, 4'h9, 4'h0, 4'h2,
       32'hffff00ff);
    idle();
  endtask

  task automatic t_narrow();
    op(32'h43c8, 0, 0, 1, 4'h3, 0, 32'h0000ffff, 5'h00, 5'h01, 4'hb, 4'hb, 4'h0,
       32'hffff0000);
    op(32'h43c8, 0, 1, 1, 4'h3, 0, 32'h0000ffff, 5'h00, 5'h01, 4'h9, 4'h0, 4'h0,
       32'hffff0000);
    // negate source fed on both read ports, though the unit reads it from the second port only
    op(32'h424a, 0, 0, 1, 4'h0, 32'h80000000, 32'h80000000, NC, NC, 4'hb, 4'h9, 4'h2,
       32'h80000000);
    op(32'h424a, 0, 0, 1, 4'h1, 0, 0, NC, NC, 4'hb, 4'h6, 4'h2, 32'h0);
    op(32'h424a, 0, 0, 1, 4'h2, 5, 5, NC, NC, 4'hb, 4'h8, 4'h2, 32'hfffffffb);
    idle();
  endtask

  task automatic t_nop_and_condition();
    op(32'hbf00, 0, 0, 1, 4'h5, 0, 0, NC, NC, 4'h8, 4'h0, 4'h0, 32'h0);
    op(32'hf3af8000, 1, 0, 1, 4'ha, 0, 0, NC, NC, 4'h8, 4'h0, 4'h0, 32'h0);
    op(32'hf07f427f, 1, 0, 0, 4'h1, 0, 0, NC, NC, 4'h8, 4'h0, 4'h0, 32'h0);
    op(32'hea6f020d, 1, 0, 0, 4'h0, 0, 0, NC, NC, 4'h8, 4'h0, 4'h0, 32'h0);
    op(32'h43c8, 0, 0, 0, 4'h3, 0, 32'h1, NC, NC, 4'h8, 4'h0, 4'h0, 32'h0);
    // plain or, not ours: no answer at all
    op(32'h4308, 0, 0, 1, 4'h0, 0, 0, NC, NC, 4'h0, 4'h0, 4'h0, 32'h0);
    idle();
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    is_wide = 1'b0;
    in_conditional_block = 1'b0;
    condition_passed = 1'b0;
    flags_in = '0;
    first_operand_data = '0;
    second_operand_data = '0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    #1;
    chk({done, writeback.en, flags_we, unpredictable}, 4'h0);
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    t_move_imm();
    t_or_complement_imm();
    t_register_forms();
    t_narrow();
    t_nop_and_condition();
    end_sim();
  end
endmodule
`default_nettype wire
